// ==== pattern_pkg.sv ====
// constants, field layout and state type of the pulse pattern engine
//------------------------------------------------------------
//------------------------------------------------------------
`default_nettype none
package pattern_pkg;
  localparam int NCH = 4;
  localparam logic [7:0] RUN_OFS = 8'h00;
  localparam logic [7:0] REALIGN_OFS = 8'h04;
  localparam logic [7:0] HALT_FLAG_OFS = 8'h08;
  localparam logic [7:0] HALT_MASK_OFS = 8'h0c;
  localparam logic [7:0] SET_OFS = 8'h10;
  localparam logic [7:0] CLR_OFS = 8'h14;
  localparam logic [7:0] READY_FLAG_OFS = 8'h18;
  localparam logic [3:0] CH0_PAGE = 4'h2;
  localparam logic [3:0] CHN_PAGE0 = 4'h3;
  localparam logic [1:0] CFG_FLD = 2'h0;
  localparam logic [1:0] PAT_FLD = 2'h1;
  localparam logic [1:0] LOOP_FLD = 2'h2;
  localparam logic [1:0] RESTART_FLD = 2'h3;
  localparam int RATE_W = 16;
  localparam int LEN_LSB = 27;
  localparam int CNT_W = 16;
  localparam int GAP_LSB = 16;
  localparam int GAP_W = 12;
  localparam int SRC1_LSB = 0;
  localparam int SRC1_EN = 7;
  localparam int SRC2_LSB = 8;
  localparam int SRC2_EN = 15;
  localparam logic [4:0] LEN_SQUARE = 5'h01;
  localparam logic [5:0] LEN_FULL = 6'h20;
  localparam logic [31:0] REG_RST = 32'h0;
  typedef enum logic {PH_SHIFT, PH_GAP} phase_t;
endpackage
`default_nettype wire

// ==== pulse_pattern_engine.sv ====
// four channel pulse pattern engine with a classic wishbone register slave
//
// The register addresses and register access over Wishbone were chosen for this implementation.
`default_nettype none
module pulse_pattern_engine import pattern_pkg::*; (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic [NCH-1:0] PATTERN_OUT,
  output logic HALT_IRQ
);
  //------------------------------------------------------------
  // decode helpers
  //------------------------------------------------------------
  // returns {valid, channel, field}
  function automatic logic [4:0] ch_dec(input logic [7:0] a);
    logic [3:0] pg;
    pg = a[7:4];
    if (pg == CH0_PAGE)
      ch_dec = {1'b1, 2'd0, a[3:2]};
    else if (pg > CHN_PAGE0 && pg < CHN_PAGE0 + 4'(NCH))
      ch_dec = {1'b1, 2'(pg - CHN_PAGE0), a[3:2]};
    else
      ch_dec = 5'h00;
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] s);
    lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  function automatic logic src_hit(input logic en, input logic [4:0] idx, input logic [NCH-1:0] ev);
    src_hit = en && idx < 5'(NCH) && ev[idx[1:0]];
  endfunction

  //------------------------------------------------------------
  // state
  //------------------------------------------------------------
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [31:0] cfg_reg [NCH];
  logic [31:0] pat_reg [NCH];
  logic [31:0] loop_reg [NCH];
  logic [31:0] rst_cfg_reg [NCH];
  logic [31:0] shadow_reg [NCH];
  logic [4:0] bitpos_reg [NCH];
  logic [RATE_W-1:0] rate_cnt_reg [NCH];
  logic [GAP_W-1:0] gap_cnt_reg [NCH];
  logic [CNT_W-1:0] left_reg [NCH];
  phase_t ph_reg [NCH];
  logic [NCH-1:0] run_reg, run_next, pend_reg, lm_reg, out_reg;
  logic [NCH-1:0] halt_flag_reg, halt_mask_reg, ready_reg, stop_q_reg;
  logic irq_reg;

  logic hit, acc, wr;
  logic [4:0] dsel;
  logic [31:0] m, rd_mux;
  logic [NCH-1:0] square, tick, last, stop, start, realign, load, restart, pat_wr, ready_clr, halt_clr;
  logic [5:0] nbits [NCH];

  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = dat_reg;
  assign PATTERN_OUT = out_reg;
  assign HALT_IRQ = irq_reg;

  //------------------------------------------------------------
  // bus slave
  //------------------------------------------------------------
  // effects happen at the edge where the master sees ack high
  assign hit = WB_CYC_I & WB_STB_I;
  assign acc = hit & ack_reg;
  assign wr = acc & WB_WE_I;
  assign m = lane_mask(WB_SEL_I);
  assign dsel = ch_dec(WB_ADR_I);

  always_comb begin
    rd_mux = REG_RST;
    case (WB_ADR_I)
      RUN_OFS: rd_mux[NCH-1:0] = run_reg;
      HALT_FLAG_OFS: rd_mux[NCH-1:0] = halt_flag_reg;
      HALT_MASK_OFS: rd_mux[NCH-1:0] = halt_mask_reg;
      READY_FLAG_OFS: rd_mux[NCH-1:0] = ready_reg;
      default: begin
        if (dsel[4]) begin
          case (dsel[1:0])
            CFG_FLD: rd_mux = cfg_reg[dsel[3:2]];
            PAT_FLD: rd_mux = pat_reg[dsel[3:2]];
            LOOP_FLD: rd_mux = loop_reg[dsel[3:2]];
            default: rd_mux = rst_cfg_reg[dsel[3:2]];
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_reg <= 1'b0;
      dat_reg <= REG_RST;
    end else begin
      ack_reg <= hit & !ack_reg;
      if (hit & !ack_reg)
        dat_reg <= WB_WE_I ? REG_RST : rd_mux;
    end
  end

  //------------------------------------------------------------
  // channel configuration
  //------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      halt_mask_reg <= '0;
      for (int i = 0; i < NCH; i++) begin
        cfg_reg[i] <= REG_RST;
        pat_reg[i] <= REG_RST;
        loop_reg[i] <= REG_RST;
        rst_cfg_reg[i] <= REG_RST;
      end
    end else if (wr) begin
      if (WB_ADR_I == HALT_MASK_OFS)
        halt_mask_reg <= (halt_mask_reg & ~m[NCH-1:0]) | (WB_DAT_I[NCH-1:0] & m[NCH-1:0]);
      for (int i = 0; i < NCH; i++) begin
        if (dsel[4] && dsel[3:2] == 2'(i)) begin
          case (dsel[1:0])
            CFG_FLD: cfg_reg[i] <= (cfg_reg[i] & ~m) | (WB_DAT_I & m);
            PAT_FLD: pat_reg[i] <= (pat_reg[i] & ~m) | (WB_DAT_I & m);
            LOOP_FLD: loop_reg[i] <= (loop_reg[i] & ~m) | (WB_DAT_I & m);
            default: rst_cfg_reg[i] <= (rst_cfg_reg[i] & ~m) | (WB_DAT_I & m);
          endcase
        end
      end
    end
  end

  //------------------------------------------------------------
  // per channel decode
  //------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      square[i] = cfg_reg[i][LEN_LSB+:5] == LEN_SQUARE;
      nbits[i] = cfg_reg[i][LEN_LSB+:5] == 5'h00 ? LEN_FULL : {1'b0, cfg_reg[i][LEN_LSB+:5]};
      tick[i] = run_reg[i] && rate_cnt_reg[i] == cfg_reg[i][RATE_W-1:0];
      last[i] = !square[i] && ph_reg[i] == PH_SHIFT && tick[i] && {1'b0, bitpos_reg[i]} == nbits[i] - 6'h01;
      stop[i] = last[i] && lm_reg[i] && left_reg[i] == CNT_W'(1);
      restart[i] = src_hit(rst_cfg_reg[i][SRC1_EN], rst_cfg_reg[i][SRC1_LSB+:5], stop_q_reg)
                 | src_hit(rst_cfg_reg[i][SRC2_EN], rst_cfg_reg[i][SRC2_LSB+:5], stop_q_reg);
      realign[i] = wr && WB_ADR_I == REALIGN_OFS && WB_DAT_I[i] && m[i];
      pat_wr[i] = wr && dsel[4] && dsel[3:2] == 2'(i) && dsel[1:0] == PAT_FLD;
      ready_clr[i] = wr && WB_ADR_I == READY_FLAG_OFS && WB_DAT_I[i] && m[i];
      halt_clr[i] = wr && WB_ADR_I == HALT_FLAG_OFS && WB_DAT_I[i] && m[i];
    end
  end

  //------------------------------------------------------------
  // run bits
  //------------------------------------------------------------
  always_comb begin
    run_next = run_reg;
    if (wr && WB_ADR_I == RUN_OFS)
      run_next = (run_reg & ~m[NCH-1:0]) | (WB_DAT_I[NCH-1:0] & m[NCH-1:0]);
    if (wr && WB_ADR_I == SET_OFS)
      run_next = run_reg | (WB_DAT_I[NCH-1:0] & m[NCH-1:0]);
    if (wr && WB_ADR_I == CLR_OFS)
      run_next = run_reg & ~(WB_DAT_I[NCH-1:0] & m[NCH-1:0]);
    run_next = (run_next & ~stop) | restart;
    // a restart on a running channel reloads it as if freshly started
    start = (run_next & ~run_reg) | (restart & run_reg);
    load = start | (last & ~stop & pend_reg);
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      run_reg <= '0;
      stop_q_reg <= '0;
    end else begin
      run_reg <= run_next;
      stop_q_reg <= stop;
    end
  end

  //------------------------------------------------------------
  // channel engines
  //------------------------------------------------------------
  // clearing run just freezes the engine; the output keeps its level
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      out_reg <= '0;
      lm_reg <= '0;
      for (int i = 0; i < NCH; i++) begin
        shadow_reg[i] <= REG_RST;
        bitpos_reg[i] <= 5'h00;
        rate_cnt_reg[i] <= '0;
        gap_cnt_reg[i] <= '0;
        left_reg[i] <= '0;
        ph_reg[i] <= PH_SHIFT;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (load[i])
          shadow_reg[i] <= pat_reg[i];
        if (start[i]) begin
          bitpos_reg[i] <= 5'h00;
          rate_cnt_reg[i] <= '0;
          ph_reg[i] <= PH_SHIFT;
          left_reg[i] <= loop_reg[i][CNT_W-1:0];
          lm_reg[i] <= loop_reg[i][CNT_W-1:0] != '0 && !square[i];
          if (square[i])
            out_reg[i] <= 1'b0;
        end else if (realign[i]) begin
          // bit 0 goes out right away, so the next tick must move on to bit 1
          bitpos_reg[i] <= square[i] ? 5'h00 : 5'h01;
          rate_cnt_reg[i] <= '0;
          ph_reg[i] <= PH_SHIFT;
          out_reg[i] <= square[i] ? 1'b0 : shadow_reg[i][0];
        end else if (run_reg[i] && ph_reg[i] == PH_GAP) begin
          // output holds the final bit during the gap
          gap_cnt_reg[i] <= gap_cnt_reg[i] - GAP_W'(1);
          if (gap_cnt_reg[i] == GAP_W'(1)) begin
            ph_reg[i] <= PH_SHIFT;
            rate_cnt_reg[i] <= '0;
            left_reg[i] <= left_reg[i] - CNT_W'(1);
          end
        end else if (run_reg[i]) begin
          rate_cnt_reg[i] <= tick[i] ? '0 : rate_cnt_reg[i] + RATE_W'(1);
          if (tick[i] && square[i])
            out_reg[i] <= ~out_reg[i];
          else if (tick[i]) begin
            out_reg[i] <= shadow_reg[i][bitpos_reg[i]];
            bitpos_reg[i] <= last[i] ? 5'h00 : bitpos_reg[i] + 5'h01;
          end
          if (last[i] && lm_reg[i] && !stop[i]) begin
            if (loop_reg[i][GAP_LSB+:GAP_W] != '0) begin
              ph_reg[i] <= PH_GAP;
              gap_cnt_reg[i] <= loop_reg[i][GAP_LSB+:GAP_W];
            end else
              left_reg[i] <= left_reg[i] - CNT_W'(1);
          end
        end
      end
    end
  end

  //------------------------------------------------------------
  // flags
  //------------------------------------------------------------
  // a hardware set in the clearing cycle wins over the clear
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pend_reg <= '0;
      ready_reg <= '0;
      halt_flag_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      pend_reg <= (pend_reg & ~load) | pat_wr;
      ready_reg <= (ready_reg & ~ready_clr) | load;
      halt_flag_reg <= (halt_flag_reg & ~halt_clr) | stop;
      irq_reg <= |(halt_flag_reg & halt_mask_reg);
    end
  end

  //------------------------------------------------------------
  // assertions on channel 0, plus the interrupt check across all channels
  //------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  property p_square;
    run_reg[0] && square[0] && tick[0] && !start[0] && !realign[0] |=> out_reg[0] != $past(out_reg[0]);
  endproperty
  a_square: assert property (p_square) else $error("square wave did not toggle");

  property p_lsb_first;
    tick[0] && !square[0] && ph_reg[0] == PH_SHIFT && !start[0] && !realign[0]
      |=> out_reg[0] == $past(shadow_reg[0][bitpos_reg[0]]);
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("wrong pattern bit out");

  property p_full_len;
    last[0] && cfg_reg[0][LEN_LSB+:5] == 5'h00 |-> bitpos_reg[0] == 5'h1f;
  endproperty
  a_full_len: assert property (p_full_len) else $error("zero selector not 32 bits");

  property p_shadow;
    start[0] |=> shadow_reg[0] == $past(pat_reg[0]) && ready_reg[0];
  endproperty
  a_shadow: assert property (p_shadow) else $error("start did not load shadow");

  property p_stop;
    stop[0] |=> !run_reg[0] && halt_flag_reg[0] ##1 stop_q_reg[0] == 1'b0;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not halt and flag");

  property p_set;
    wr && WB_ADR_I == SET_OFS && WB_DAT_I[0] && m[0] && !stop[0] |=> run_reg[0];
  endproperty
  a_set: assert property (p_set) else $error("atomic set missed");

  property p_clr;
    wr && WB_ADR_I == CLR_OFS && WB_DAT_I[0] && m[0] && !restart[0] |=> !run_reg[0] && !stop_q_reg[0];
  endproperty
  a_clr: assert property (p_clr) else $error("atomic clear missed");

  property p_realign;
    realign[0] && !start[0] |=> bitpos_reg[0] == (square[0] ? 5'h00 : 5'h01) && (!square[0] || !out_reg[0]);
  endproperty
  a_realign: assert property (p_realign) else $error("realign failed");

  property p_gap_hold;
    ph_reg[0] == PH_GAP && !start[0] && !realign[0] |=> $stable(out_reg[0]);
  endproperty
  a_gap_hold: assert property (p_gap_hold) else $error("output moved in gap");

  property p_restart;
    restart[0] |=> run_reg[0] && bitpos_reg[0] == 5'h00;
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not start");

  property p_irq;
    ##1 HALT_IRQ == |($past(halt_flag_reg) & $past(halt_mask_reg));
  endproperty
  a_irq: assert property (p_irq) else $error("irq not gated by mask");

  c_stop: cover property (stop[0]);
  c_reload: cover property (last[0] && pend_reg[0] && !stop[0]);
  c_gap: cover property (ph_reg[0] == PH_GAP ##1 ph_reg[0] == PH_SHIFT);
  c_restart: cover property (restart[0] && run_reg[0]);
endmodule
`default_nettype wire

// ==== pattern_sink.sv ====
// pin load model counting rising edges on each pattern output
`default_nettype none
module pattern_sink import pattern_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [NCH-1:0] pins,
  output logic [NCH-1:0][15:0] rise_count
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [NCH-1:0] last_reg;
  // pins are only read; the load never drives back, so no wire resolution is needed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_reg <= '0;
      rise_count <= '0;
    end else begin
      last_reg <= pins;
      for (int i = 0; i < NCH; i++) begin
        if (pins[i] && !last_reg[i]) begin
          rise_count[i] <= rise_count[i] + 16'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== pulse_pattern_engine_test.sv ====
// self-checking bench for the pulse pattern engine
`default_nettype none
module pulse_pattern_engine_test import pattern_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic REF_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] dat_o;
  logic ack;
  logic irq;
  logic [NCH-1:0] pout;
  logic [NCH-1:0][15:0] rises;
  int err_total = 0;
  int check_count = 0;
  always #2.5 REF_CLK = ~REF_CLK;
  pulse_pattern_engine dut_u (.REF_CLK(REF_CLK), .RST_N(RST_N), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .PATTERN_OUT(pout), .HALT_IRQ(irq));
  pattern_sink sink_u (.clk(REF_CLK), .rst_n(RST_N), .pins(pout), .rise_count(rises));
  //------------------------------------------------------------
  // shared tasks
  //------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // one classic cycle; request held until ack is seen at an edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge REF_CLK);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 50) begin
      err_total++;
      $display("Error at %0t: bus answer missing", $time);
      end_sim();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0, q);
  endtask
  function automatic logic [7:0] page(input int ch);
    case (ch)
      0: page = 8'h20;
      1: page = 8'h40;
      2: page = 8'h50;
      default: page = 8'h60;
    endcase
  endfunction
  // first sample lands just after the current edge when now is set
  task automatic grab(input int ch, input int n, input bit now, output logic [63:0] b);
    b = '0;
    for (int i = 0; i < n; i++) begin
      if (i > 0 || !now) begin
        @(posedge REF_CLK);
      end
      #1 b[i] = pout[ch];
    end
  endtask
  //------------------------------------------------------------
  // test sequence
  //------------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic [63:0] b;
    logic [15:0] r0;
    int n;
    repeat (12) @(posedge REF_CLK);
    RST_N <= 1'b1;
    rd(RUN_OFS, q);
    chk(q, 32'h0, "run reset");
    rd(HALT_MASK_OFS, q);
    chk(q, 32'h0, "mask reset");
    rd(SET_OFS, q);
    chk(q, 32'h0, "write-only read");
    wr(8'h1c, 32'hffff_ffff);
    rd(8'h1c, q);
    chk(q, 32'h0, "unmapped read");
    $display("test reset done");
    wr(page(0), 32'h2000_0000);
    wr(page(0) + 8'h4, 32'hffff_fff6);
    wr(RUN_OFS, 32'h1);
    grab(0, 8, 0, b);
    chk(32'(b[7:0]), 32'h66, "four bit pattern");
    wr(page(1), 32'h0);
    wr(page(1) + 8'h4, 32'h8000_0001);
    wr(RUN_OFS, 32'h3);
    grab(1, 64, 0, b);
    chk(b[31:0], 32'h8000_0001, "full pattern first");
    chk(b[63:32], 32'h8000_0001, "full pattern second");
    wr(page(2), 32'h0800_0001);
    wr(page(2) + 8'h4, 32'haaaa_5555);
    r0 = rises[2];
    wr(SET_OFS, 32'h5);
    repeat (16) @(posedge REF_CLK);
    chk(32'(rises[2] - r0), 32'h4, "square rises");
    rd(RUN_OFS, q);
    chk(q, 32'h7, "run after set");
    $display("test modes done");
    wr(REALIGN_OFS, 32'h5);
    #1 chk(32'(pout[2]), 32'h0, "square realigned low");
    grab(0, 4, 1, b);
    chk(32'(b[3:0]), 32'h6, "pattern realigned");
    rd(READY_FLAG_OFS, q);
    chk(32'(q[1:0]), 32'h3, "ready after load");
    wr(READY_FLAG_OFS, 32'h1);
    rd(READY_FLAG_OFS, q);
    chk(32'(q[0]), 32'h0, "ready cleared");
    wr(page(0) + 8'h4, 32'h0000_000f);
    repeat (8) @(posedge REF_CLK);
    rd(READY_FLAG_OFS, q);
    chk(32'(q[0]), 32'h1, "ready after reload");
    grab(0, 4, 0, b);
    chk(32'(b[3:0]), 32'hf, "reloaded pattern");
    $display("test shadow done");
    wr(CLR_OFS, 32'h2);
    rd(RUN_OFS, q);
    chk(q, 32'h5, "run after clear");
    rd(HALT_FLAG_OFS, q);
    chk(q, 32'h0, "no stop on clear");
    wr(page(1), 32'h1000_0000);
    wr(page(1) + 8'h4, 32'h2);
    wr(page(1) + 8'h8, 32'h0005_0003);
    wr(page(3), 32'h0800_0000);
    wr(page(3) + 8'hc, 32'h0000_0081);
    wr(HALT_MASK_OFS, 32'h2);
    r0 = rises[1];
    wr(SET_OFS, 32'h2);
    n = 0;
    do begin
      rd(RUN_OFS, q);
      n++;
    end while (q[1] !== 1'b0 && n < 60);
    chk(32'(q[1]), 32'h0, "run cleared by hardware");
    chk(32'(rises[1] - r0), 32'h3, "pattern repeats");
    rd(HALT_FLAG_OFS, q);
    chk(q, 32'h2, "stop flag");
    chk(32'(irq), 32'h1, "stop interrupt");
    rd(RUN_OFS, q);
    chk(q, 32'hd, "restart target started");
    r0 = rises[3];
    repeat (8) @(posedge REF_CLK);
    chk(32'(rises[3] - r0), 32'h4, "restarted square runs");
    wr(HALT_FLAG_OFS, 32'h2);
    repeat (2) @(posedge REF_CLK);
    chk(32'(irq), 32'h0, "interrupt after flag clear");
    $display("test repeat done");
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge REF_CLK);
    err_total++;
    $display("Error at %0t: run too long", $time);
    end_sim();
  end
endmodule
`default_nettype wire
